/* rtl/rbsp_regs.vh */
// Register map, field positions and framing constants of the receive backplane serial port.
// Assumes inclusion by its bare name from the design file; holds definitions only.
`ifndef RBSP_REGS_VH
`define RBSP_REGS_VH

`define RBSP_AXI_AW        8
`define RBSP_OFF_CFG       8'h00
`define RBSP_OFF_STAT      8'h04
`define RBSP_WORD_LSB      2

`define RBSP_CFG_SYNC_OUT  0
`define RBSP_CFG_E1        1
`define RBSP_CFG_ESTORE    2
`define RBSP_CFG_IBO       3
`define RBSP_CFG_DWIDE     4
`define RBSP_CFG_CRC4      5
`define RBSP_CFG_NFR_HI    7
`define RBSP_CFG_NFR_LO    6
`define RBSP_CFG_SLOT_HI   10
`define RBSP_CFG_SLOT_LO   8
`define RBSP_CFG_W         11
`define RBSP_CFG_RST       11'h000

`define RBSP_STAT_SLIP     0
`define RBSP_STAT_UNDER    1
`define RBSP_STAT_FRM_HI   7
`define RBSP_STAT_FRM_LO   4

`define RBSP_T1_LAST_BIT   8'hc0
`define RBSP_E1_LAST_BIT   8'hff
`define RBSP_T1_LAST_FRM   4'hb
`define RBSP_E1_LAST_FRM   4'hf
`define RBSP_T1_SIG_FRM_A  4'h5
`define RBSP_T1_SIG_FRM_B  4'hb
`define RBSP_CRC4_SUB_FRM  4'h8
`define RBSP_IBO_NFR_2     2'h0
`define RBSP_IBO_NFR_4     2'h1

`define RBSP_RESP_OKAY     2'b00
`define RBSP_RESP_SLVERR   2'b10

`endif

/* rtl/rbsp_top.v */
// Receive backplane serial port of one framer channel: line-side framing, a two-entry
// elastic buffer, backplane-side serial output and the two-way sync pin, with AXI4-Lite registers.
// Assumes line clock, line rails, backplane clock and sync pin are asynchronous to aclk and
// much slower than it; the AXI4-Lite master runs on aclk.
`timescale 1ns/1ps
`default_nettype none
`include "rbsp_regs.vh"

module rbsp_top (
  input  wire                       aclk,
  input  wire                       aresetn,
  input  wire [`RBSP_AXI_AW-1:0]    s_axi_awaddr,
  input  wire [2:0]                 s_axi_awprot,
  input  wire                       s_axi_awvalid,
  output reg                        s_axi_awready,
  input  wire [31:0]                s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  input  wire                       s_axi_wvalid,
  output reg                        s_axi_wready,
  output reg  [1:0]                 s_axi_bresp,
  output reg                        s_axi_bvalid,
  input  wire                       s_axi_bready,
  input  wire [`RBSP_AXI_AW-1:0]    s_axi_araddr,
  input  wire [2:0]                 s_axi_arprot,
  input  wire                       s_axi_arvalid,
  output reg                        s_axi_arready,
  output reg  [31:0]                s_axi_rdata,
  output reg  [1:0]                 s_axi_rresp,
  output reg                        s_axi_rvalid,
  input  wire                       s_axi_rready,
  input  wire                       line_clock_in,
  input  wire                       line_input_positive,
  input  wire                       line_input_negative,
  input  wire                       receive_backplane_clock,
  output reg                        receive_clock_out,
  output reg                        receive_serial_out,
  input  wire                       receive_sync_pin_i,
  output reg                        receive_sync_pin_o,
  output reg                        receive_sync_pin_oe
);

  // Last bit index of a frame for the selected line rate.
  function [7:0] last_bit;
    input e1;
    begin
      last_bit = e1 ? `RBSP_E1_LAST_BIT : `RBSP_T1_LAST_BIT;
    end
  endfunction

  // Sync pulse level for a given bit and frame position.
  function sync_level;
    input [7:0] bitn;
    input [3:0] frm;
    input       e1;
    input       dwide;
    input       crc4;
    reg         sig;
    begin
      sig = (frm == `RBSP_T1_SIG_FRM_A) || (frm == `RBSP_T1_SIG_FRM_B);
      if (e1) begin
        sync_level = (bitn == 8'h00) && ((frm == 4'h0) || (crc4 && (frm == `RBSP_CRC4_SUB_FRM)));
      end else begin
        sync_level = (bitn == 8'h00) || (dwide && sig && (bitn == 8'h01));
      end
    end
  endfunction

  reg  [`RBSP_CFG_W-1:0]    cfg_r;
  reg                       slip_r;
  reg                       under_r;
  reg                       lclk_s1_r;
  reg                       lclk_s2_r;
  reg                       lclk_d_r;
  reg                       pos_s1_r;
  reg                       pos_s2_r;
  reg                       neg_s1_r;
  reg                       neg_s2_r;
  reg                       bclk_s1_r;
  reg                       bclk_s2_r;
  reg                       bclk_d_r;
  reg                       sync_s1_r;
  reg                       sync_s2_r;
  reg                       sync_d_r;
  reg  [7:0]                lbit_r;
  reg  [3:0]                lfrm_r;
  reg  [7:0]                bbit_r;
  reg  [3:0]                bfrm_r;
  reg  [2:0]                slot_r;
  reg                       buf_mem_r [0:1];
  reg                       buf_wp_r;
  reg                       buf_rp_r;
  reg  [1:0]                buf_cnt_r;
  reg                       aw_hold_r;
  reg                       w_hold_r;
  reg  [`RBSP_AXI_AW-1:0]   awaddr_r;
  reg  [31:0]               wdata_r;
  reg  [3:0]                wstrb_r;
  reg                       ar_pend_r;
  reg  [`RBSP_AXI_AW-1:0]   araddr_r;

  wire                      cfg_sync_out = cfg_r[`RBSP_CFG_SYNC_OUT];
  wire                      cfg_e1       = cfg_r[`RBSP_CFG_E1];
  wire                      cfg_estore   = cfg_r[`RBSP_CFG_ESTORE];
  wire                      cfg_ibo      = cfg_r[`RBSP_CFG_IBO];
  wire                      cfg_dwide    = cfg_r[`RBSP_CFG_DWIDE];
  wire                      cfg_crc4     = cfg_r[`RBSP_CFG_CRC4];
  wire [1:0]                cfg_nfr      = cfg_r[`RBSP_CFG_NFR_HI:`RBSP_CFG_NFR_LO];
  wire [2:0]                cfg_slot     = cfg_r[`RBSP_CFG_SLOT_HI:`RBSP_CFG_SLOT_LO];
  wire                      bp_mode      = cfg_estore | cfg_ibo;

  wire                      line_edge    = lclk_s2_r & ~lclk_d_r;
  // The backplane clock is ignored entirely unless the store or interleaving is on.
  wire                      bp_edge      = bclk_s2_r & ~bclk_d_r & bp_mode;
  wire                      sync_in_edge = sync_s2_r & ~sync_d_r & cfg_estore & ~cfg_sync_out;
  wire [2:0]                slot_last    = (cfg_nfr == `RBSP_IBO_NFR_2) ? 3'h1 :
                                           (cfg_nfr == `RBSP_IBO_NFR_4) ? 3'h3 : 3'h7;
  wire                      my_slot      = ~cfg_ibo | (slot_r == cfg_slot);
  wire                      line_bit     = pos_s2_r | neg_s2_r;
  wire                      buf_in_ready = (buf_cnt_r != 2'h2);
  wire                      buf_push     = line_edge & buf_in_ready;
  wire                      buf_out_rdy  = bp_mode ? (bp_edge & my_slot) : 1'b1;
  wire                      buf_pop      = buf_out_rdy & (buf_cnt_r != 2'h0);
  wire                      slip_set     = line_edge & ~buf_in_ready;
  wire                      under_set    = bp_mode & bp_edge & my_slot & (buf_cnt_r == 2'h0);

  // Synchronisers: the first stage is never read by logic; the second stage and its delayed copy are.
  always @(posedge aclk) begin
    if (!aresetn) begin
      lclk_s1_r <= 1'b0;
      lclk_s2_r <= 1'b0;
      lclk_d_r  <= 1'b0;
      pos_s1_r  <= 1'b0;
      pos_s2_r  <= 1'b0;
      neg_s1_r  <= 1'b0;
      neg_s2_r  <= 1'b0;
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_d_r  <= 1'b0;
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      sync_d_r  <= 1'b0;
    end else begin
      lclk_s1_r <= line_clock_in;
      lclk_s2_r <= lclk_s1_r;
      lclk_d_r  <= lclk_s2_r;
      pos_s1_r  <= line_input_positive;
      pos_s2_r  <= pos_s1_r;
      neg_s1_r  <= line_input_negative;
      neg_s2_r  <= neg_s1_r;
      bclk_s1_r <= receive_backplane_clock;
      bclk_s2_r <= bclk_s1_r;
      bclk_d_r  <= bclk_s2_r;
      sync_s1_r <= receive_sync_pin_i;
      sync_s2_r <= sync_s1_r;
      sync_d_r  <= sync_s2_r;
    end
  end

  // Line-side framer, advanced only on recovered clock edges.
  always @(posedge aclk) begin
    if (!aresetn) begin
      lbit_r            <= 8'h00;
      lfrm_r            <= 4'h0;
      receive_clock_out <= 1'b0;
    end else begin
      receive_clock_out <= lclk_s2_r;
      if (line_edge) begin
        if (lbit_r >= last_bit(cfg_e1)) begin
          lbit_r <= 8'h00;
          if (lfrm_r >= (cfg_e1 ? `RBSP_E1_LAST_FRM : `RBSP_T1_LAST_FRM)) begin
            lfrm_r <= 4'h0;
          end else begin
            lfrm_r <= lfrm_r + 4'h1;
          end
        end else begin
          lbit_r <= lbit_r + 8'h01;
        end
      end
    end
  end

  // Backplane-side bit counter and slot counter; an input sync pulse realigns the frame when the elastic store is on and the sync pin is an input.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bbit_r <= 8'h00;
      bfrm_r <= 4'h0;
      slot_r <= 3'h0;
    end else begin
      if (bp_edge) begin
        slot_r <= (slot_r >= slot_last) ? 3'h0 : slot_r + 3'h1;
      end
      if (sync_in_edge) begin
        bbit_r <= 8'h00;
        bfrm_r <= 4'h0;
      end else if (bp_edge && my_slot) begin
        if (bbit_r >= last_bit(cfg_e1)) begin
          bbit_r <= 8'h00;
          if (bfrm_r >= (cfg_e1 ? `RBSP_E1_LAST_FRM : `RBSP_T1_LAST_FRM)) begin
            bfrm_r <= 4'h0;
          end else begin
            bfrm_r <= bfrm_r + 4'h1;
          end
        end else begin
          bbit_r <= bbit_r + 8'h01;
        end
      end
    end
  end

  // Two-entry buffer between line and backplane. The line cannot be stalled, so a push into a
  // full buffer is dropped and counted as a slip; a starved backplane read repeats the last bit, or in interleaved mode the 0 of other framers' slots.
  always @(posedge aclk) begin
    if (!aresetn) begin
      buf_mem_r[0] <= 1'b0;
      buf_mem_r[1] <= 1'b0;
      buf_wp_r     <= 1'b0;
      buf_rp_r     <= 1'b0;
      buf_cnt_r    <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_mem_r[buf_wp_r] <= line_bit;
        buf_wp_r            <= ~buf_wp_r;
      end
      if (buf_pop) begin
        buf_rp_r <= ~buf_rp_r;
      end
      if (buf_push && !buf_pop) begin
        buf_cnt_r <= buf_cnt_r + 2'h1;
      end else if (buf_pop && !buf_push) begin
        buf_cnt_r <= buf_cnt_r - 2'h1;
      end
    end
  end

  // Serial output and sync pin.
  always @(posedge aclk) begin
    if (!aresetn) begin
      receive_serial_out  <= 1'b0;
      receive_sync_pin_o  <= 1'b0;
      receive_sync_pin_oe <= 1'b0;
    end else begin
      receive_sync_pin_oe <= cfg_sync_out;
      if (buf_pop) begin
        receive_serial_out <= buf_mem_r[buf_rp_r];
      end else if (cfg_ibo && bp_edge && !my_slot) begin
        receive_serial_out <= 1'b0;
      end
      if (!cfg_sync_out) begin
        receive_sync_pin_o <= 1'b0;
      end else if (!bp_mode && line_edge) begin
        receive_sync_pin_o <= sync_level(lbit_r, lfrm_r, cfg_e1, cfg_dwide, cfg_crc4);
      end else if (bp_mode && bp_edge && my_slot) begin
        receive_sync_pin_o <= sync_level(bbit_r, bfrm_r, cfg_e1, cfg_dwide, cfg_crc4);
      end
    end
  end

  // AXI4-Lite write path: address and data are taken independently, the write happens once both
  // are held, and the response follows.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RBSP_RESP_OKAY;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= {`RBSP_AXI_AW{1'b0}};
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      cfg_r         <= `RBSP_CFG_RST;
      slip_r        <= 1'b0;
      under_r       <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !s_axi_awready && !aw_hold_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_hold_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_axi_wready && !w_hold_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_hold_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r[`RBSP_AXI_AW-1:`RBSP_WORD_LSB] == `RBSP_OFF_CFG >> `RBSP_WORD_LSB) begin
          s_axi_bresp <= `RBSP_RESP_OKAY;
          if (wstrb_r[0]) begin
            cfg_r[7:0] <= wdata_r[7:0];
          end
          if (wstrb_r[1]) begin
            cfg_r[`RBSP_CFG_W-1:8] <= wdata_r[`RBSP_CFG_W-1:8];
          end
        end else if (awaddr_r[`RBSP_AXI_AW-1:`RBSP_WORD_LSB] == `RBSP_OFF_STAT >> `RBSP_WORD_LSB) begin
          s_axi_bresp <= `RBSP_RESP_OKAY;
        end else begin
          s_axi_bresp <= `RBSP_RESP_SLVERR;
        end
      end
      // Sticky flags: a new event in the clearing cycle keeps the flag set.
      if (aw_hold_r && w_hold_r && !s_axi_bvalid && wstrb_r[0] &&
          (awaddr_r[`RBSP_AXI_AW-1:`RBSP_WORD_LSB] == `RBSP_OFF_STAT >> `RBSP_WORD_LSB)) begin
        slip_r  <= slip_set | (slip_r & ~wdata_r[`RBSP_STAT_SLIP]);
        under_r <= under_set | (under_r & ~wdata_r[`RBSP_STAT_UNDER]);
      end else begin
        slip_r  <= slip_r | slip_set;
        under_r <= under_r | under_set;
      end
    end
  end

  // AXI4-Lite read path.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RBSP_RESP_OKAY;
      ar_pend_r     <= 1'b0;
      araddr_r      <= {`RBSP_AXI_AW{1'b0}};
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !ar_pend_r && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        ar_pend_r     <= 1'b1;
        araddr_r      <= s_axi_araddr;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (ar_pend_r && !s_axi_arready && !s_axi_rvalid) begin
        ar_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (araddr_r[`RBSP_AXI_AW-1:`RBSP_WORD_LSB] == `RBSP_OFF_CFG >> `RBSP_WORD_LSB) begin
          s_axi_rresp <= `RBSP_RESP_OKAY;
          s_axi_rdata <= {{(32-`RBSP_CFG_W){1'b0}}, cfg_r};
        end else if (araddr_r[`RBSP_AXI_AW-1:`RBSP_WORD_LSB] == `RBSP_OFF_STAT >> `RBSP_WORD_LSB) begin
          s_axi_rresp <= `RBSP_RESP_OKAY;
          s_axi_rdata <= {24'h000000, lfrm_r, 2'b00, under_r, slip_r};
        end else begin
          s_axi_rresp <= `RBSP_RESP_SLVERR;
          s_axi_rdata <= 32'h00000000;
        end
      end
    end
  end

endmodule // rbsp_top
`default_nettype wire

/* bench/rbsp_chk.sv */
// Concurrent checks on the ports of the receive backplane serial port.
// Assumes one aclk domain with synchronous active-low aresetn; bound to rbsp_top below.
`timescale 1ns/1ps
`default_nettype none
module rbsp_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        line_clock_in,
  input wire logic        receive_backplane_clock,
  input wire logic        receive_clock_out,
  input wire logic        receive_serial_out,
  input wire logic        receive_sync_pin_o,
  input wire logic        receive_sync_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since the last sampled rising edge of each raw clock pin, saturating.
  logic [3:0] lage_r;
  logic [3:0] bage_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      lage_r <= 4'hf;
      bage_r <= 4'hf;
    end else begin
      lage_r <= $rose(line_clock_in) ? 4'h0 : lage_r + {3'h0, lage_r != 4'hf};
      bage_r <= $rose(receive_backplane_clock) ? 4'h0 : bage_r + {3'h0, bage_r != 4'hf};
    end
  end
  chk_oe_after_reset: assert property ($rose(aresetn) |-> !receive_sync_pin_oe)
    else $error("sync pin enabled at reset release");
  chk_quiet_input: assert property (!receive_sync_pin_oe |-> !receive_sync_pin_o)
    else $error("sync level driven while the pin is an input");
  chk_clock_follows: assert property ($rose(line_clock_in) |-> ##[2:4] $rose(receive_clock_out))
    else $error("recovered clock output did not follow the line clock");
  // A mode write may drain the buffer at once, so a change just after a write answer is legal.
  chk_ser_timing: assert property ($changed(receive_serial_out) |-> lage_r <= 4'h6 || bage_r <= 4'h7 ||
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("serial output changed away from any clock edge");
  chk_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  chk_wready_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready longer than one cycle");
  chk_write_answer: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response after address and data");
  chk_read_answer: assert property (s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("no read response after address");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before bready");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_sync_out: cover property ($rose(receive_sync_pin_oe));
  cov_bp_data: cover property ($changed(receive_serial_out) && bage_r <= 4'h7 && lage_r > 4'h6);
endmodule // rbsp_chk

bind rbsp_top rbsp_chk chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_clock_in(line_clock_in),
  .receive_backplane_clock(receive_backplane_clock), .receive_clock_out(receive_clock_out),
  .receive_serial_out(receive_serial_out), .receive_sync_pin_o(receive_sync_pin_o),
  .receive_sync_pin_oe(receive_sync_pin_oe));
`default_nettype wire

/* bench/rbsp_bp_model.sv */
// Backplane partner: system clock and frame sync pulse into the receive port.
// Assumes run is raised only while the elastic store or interleaved mode is on.
`timescale 1ns/1ps
`default_nettype none
module rbsp_bp_model (
  input  wire logic run,
  input  wire logic pulse,
  output var  logic bp_clk,
  output var  logic sync_drv
);
  logic armed_r;
  initial bp_clk = 1'b0;
  initial sync_drv = 1'b0;
  initial armed_r = 1'b0;
  // 8.192 MHz is a multiple of 2.048 MHz, so the same clock suits interleaved mode.
  always begin
    #61;
    bp_clk = run ? ~bp_clk : 1'b0;
  end
  // One clock wide pulse per request, launched on the falling edge so it is settled at the rising one.
  always @(negedge bp_clk) begin
    sync_drv <= pulse & ~armed_r;
    armed_r <= pulse;
  end
endmodule // rbsp_bp_model
`default_nettype wire

/* bench/rbsp_top_test.sv */
// Self-checking bench of the receive backplane serial port.
// Assumes design, checker and backplane model are compiled first; line clock runs free at 64 ns.
`timescale 1ns/1ps
`default_nettype none
module rbsp_top_test;
  logic aclk = 0, aresetn = 0, lclk = 0, lpos = 0, lneg = 0, b = 0, run = 0, pulse = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, late_ready = 0;
  logic [7:0] awaddr = 0, araddr = 0, lsr = 8'h5b;
  logic [31:0] wdata = 0;
  wire logic awready, wready, bvalid, arready, rvalid, rco, ser, so, soe, bpclk, sdrv, sync_w;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int bad_count = 0, tests_run = 0, w, mx;

  always #2.5 aclk = ~aclk;
  always #32 lclk = ~lclk;
  always @(negedge lclk) begin
    lsr <= {lsr[6:0], lsr[7] ^ lsr[5]};
    lpos <= lsr[0] & lsr[3];
    lneg <= lsr[0] & ~lsr[3];
  end
  assign sync_w = soe ? so : sdrv;

  rbsp_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .line_clock_in(lclk), .line_input_positive(lpos),
    .line_input_negative(lneg), .receive_backplane_clock(bpclk), .receive_clock_out(rco),
    .receive_serial_out(ser), .receive_sync_pin_i(sync_w), .receive_sync_pin_o(so),
    .receive_sync_pin_oe(soe));
  rbsp_bp_model bp_u (.run(run), .pulse(pulse), .bp_clk(bpclk), .sync_drv(sdrv));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Response ready goes up with the request; with late_ready set it waits for the answer,
  // so the slave's hold of the response is exercised too. Only the watchdog ends a wait.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !late_ready;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
    chk(32'(r), 32'(er));
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !late_ready;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    chk(d & m, e);
    chk(32'(r), 32'(er));
  endtask

  task automatic width(input int n);
    w = 0;
    mx = 0;
    repeat (n) begin
      @(posedge aclk);
      w = so ? w + 1 : 0;
      if (w > mx) mx = w;
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(soe), 32'h0);
    axr(8'h00, 32'hffffffff, 32'h0, 2'b00);
    late_ready = 1'b1;
    axr(8'h08, 32'hffffffff, 32'h0, 2'b10);
    axw(8'h08, 32'h1, 2'b10);
    late_ready = 1'b0;
    axr(8'h00, 32'hffffffff, 32'h0, 2'b00);
    repeat (16) begin
      @(posedge lclk);
      b = lpos | lneg;
      repeat (7) @(posedge aclk);
      chk(32'(ser), 32'(b));
      chk(32'(rco), 32'h1);
    end
    axw(8'h00, 32'hfffff001, 2'b00);
    axr(8'h00, 32'hffffffff, 32'h001, 2'b00);
    chk(32'(soe), 32'h1);
    width(2600);
    chk(32'(mx >= 10 && mx <= 15), 32'h1);
    axw(8'h00, 32'h11, 2'b00);
    width(30000);
    chk(32'(mx >= 22 && mx <= 29), 32'h1);
    // E1 with CRC-4 marks: a sync pulse may only stand in frame 0 or 8 of the line framer.
    axw(8'h00, 32'h23, 2'b00);
    do @(posedge aclk); while (so);
    do @(posedge aclk); while (!so);
    axr(8'h04, 32'h70, 32'h0, 2'b00);
    axw(8'h00, 32'h4, 2'b00);
    run <= 1'b1;
    pulse <= 1'b1;
    repeat (30) @(posedge aclk);
    pulse <= 1'b0;
    repeat (300) @(posedge aclk);
    axr(8'h04, 32'h1, 32'h1, 2'b00);
    // Own slot 7 never comes round on a two-framer bus, so this framer must keep its output low.
    axw(8'h00, 32'h708, 2'b00);
    repeat (200) @(posedge aclk);
    chk(32'(ser), 32'h0);
    axw(8'h00, 32'h0, 2'b00);
    run <= 1'b0;
    axw(8'h04, 32'h3, 2'b00);
    axr(8'h04, 32'h3, 32'h0, 2'b00);
    report_and_stop;
  end

  // At most about 60000 cycles are needed, most of them in the two sync pulse width measurements.
  initial begin
    repeat (90000) @(posedge aclk);
    bad_count++;
    report_and_stop;
  end
endmodule // rbsp_top_test
`default_nettype wire
